// [design/rtrk_tracking_loop.sv]
// Purpose: type II tracking loop of a resolver-to-digital converter
// Assumes: sine and cosine samples come from adc logic on clk, taken at each sample tick
// Notes:   one carrier period is 32 sample ticks; the compensator runs once per period
`timescale 1ns/10ps
`include "rtrk_defs.svh"
module rtrk_tracking_loop (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire rtrk_pkg::rtrk_smp_t    sin_in,
    input  wire rtrk_pkg::rtrk_smp_t    cos_in,
    input  wire rtrk_pkg::rtrk_bw_t     bw_sel,
    input  wire logic                   bw_load,
    input  wire logic                   auto_bw_en,
    output rtrk_pkg::rtrk_trig_t        exc_ref,
    output logic                        smp_tick,
    output logic [15:0]                 angle,
    output logic signed [15:0]          speed,
    output rtrk_pkg::rtrk_eps_t         deviation,
    output rtrk_pkg::rtrk_bw_t          bw_level,
    output logic                        loop_update
);

    rtrk_pkg::rtrk_state_s  st;
    rtrk_pkg::rtrk_state_s  next_st;
    logic                   tick_q;
    logic                   next_tick;

    rtrk_pkg::rtrk_trig_t   est_sin;
    rtrk_pkg::rtrk_trig_t   est_cos;
    rtrk_pkg::rtrk_trig_t   car_sin;
    logic signed [27:0]     prod_a;
    logic signed [27:0]     prod_b;
    logic signed [28:0]     diff;
    logic signed [14:0]     err;
    logic                   car_pos;
    rtrk_pkg::rtrk_eps_t    dem;
    rtrk_pkg::rtrk_eps_t    acc_sum;
    logic [19:0]            eps_mag;
    logic                   dev_big;
    logic                   dev_small;
    logic signed [31:0]     eps_ext;
    logic [4:0]             kp_sh;
    logic [4:0]             ki_sh;
    logic signed [31:0]     p_term;
    logic signed [31:0]     i_step;
    logic signed [31:0]     integ_sum;
    logic                   tick;
    logic                   cyc_end;

    // table lookups for the held angle and for the carrier
    rtrk_sincos u_est (
        .ang    (st.ang[31:16]),
        .sin_v  (est_sin),
        .cos_v  (est_cos)
    );

    rtrk_sincos u_car (
        .ang    ({st.car_ph, 11'h000}),
        .sin_v  (car_sin),
        .cos_v  ()
    );

    assign tick    = (st.div == `RTRK_SMP_LAST);
    assign cyc_end = tick && (st.car_ph == `RTRK_PH_LAST);

    // cross products of resolver signals and held-angle table values
    assign prod_b  = cos_in * est_sin;
    assign prod_a  = sin_in * est_cos;
    assign diff    = 29'(prod_a) - 29'(prod_b);
    assign err     = $signed(diff[28:14]);

    // detector uses the carrier polarity of the phase loaded into exc at this tick, one phase ahead of the sample
    assign car_pos = ~st.car_ph[4];
    assign dem     = car_pos ? 20'(err) : -20'(err);
    assign acc_sum = st.acc + dem;

    assign eps_mag   = acc_sum[19] ? 20'(-acc_sum) : 20'(acc_sum);
    assign dev_big   = (eps_mag > `RTRK_EPS_HI);
    assign dev_small = (eps_mag < `RTRK_EPS_LO);

    // gains grow with bandwidth: kp linear, ki square
    assign eps_ext   = 32'(acc_sum);
    assign kp_sh     = `RTRK_KP_SH0 + {2'b00, st.bw};
    assign ki_sh     = `RTRK_KI_SH0 + {1'b0, st.bw, 1'b0};
    assign p_term    = eps_ext <<< kp_sh;
    assign i_step    = eps_ext <<< ki_sh;
    assign integ_sum = st.integ + i_step;

    always_comb begin
        next_st     = st;
        next_st.upd = 1'b0;
        next_tick   = tick;
        next_st.div = tick ? 9'h000 : st.div + 9'h001;
        if (tick) begin
            next_st.car_ph = st.car_ph + 5'h01;
            next_st.exc    = car_sin;
            // unsigned wrap of the 32-bit accumulator covers both directions
            next_st.ang    = st.ang + st.vel;
            next_st.acc    = acc_sum;
            if (st.car_ph == `RTRK_PH_LAST) begin
                next_st.acc   = 20'sh00000;
                next_st.eps   = acc_sum;
                next_st.integ = integ_sum;
                // no clamp on velocity, so top speed does not depend on bandwidth
                next_st.vel   = integ_sum + p_term;
                next_st.upd   = 1'b1;
                if (!auto_bw_en) begin
                    next_st.bw     = st.cfg_bw;
                    next_st.stable = 8'h00;
                end else if (dev_big) begin
                    next_st.bw     = `RTRK_BW_MAX;
                    next_st.stable = 8'h00;
                end else if (dev_small) begin
                    if (st.stable == `RTRK_STABLE_LAST) begin
                        next_st.stable = 8'h00;
                        if (st.bw > `RTRK_BW_AUTO_MIN) begin
                            next_st.bw = st.bw - 3'h1;
                        end
                    end else begin
                        next_st.stable = st.stable + 8'h01;
                    end
                end else begin
                    next_st.stable = 8'h00;
                end
            end
        end
        if (bw_load) begin
            next_st.cfg_bw = bw_sel;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st        <= '{div: 9'h000, car_ph: 5'h00, exc: 16'sh0000, acc: 20'sh00000,
                           eps: 20'sh00000, integ: `RTRK_VEL_RST, vel: `RTRK_VEL_RST,
                           ang: `RTRK_ANG_RST, cfg_bw: `RTRK_BW_DEFAULT, bw: `RTRK_BW_DEFAULT,
                           stable: 8'h00, upd: 1'b0};
            tick_q    <= 1'b0;
        end else begin
            st        <= next_st;
            tick_q    <= next_tick;
        end
    end

    assign exc_ref     = st.exc;
    assign smp_tick    = tick_q;
    assign angle       = st.ang[31:16];
    assign speed       = st.vel[31:16];
    assign deviation   = st.eps;
    assign bw_level    = st.bw;
    assign loop_update = st.upd;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_cycle_end;
        cyc_end;
    endsequence

    sequence s_step_seen;
        ##1 st.upd;
    endsequence

    sequence s_tick_gap;
        ##1 (!tick) [*8];
    endsequence

    a_tick_spacing: assert property (tick |-> s_tick_gap)
        else $error("sample ticks closer than the divider allows");

    a_exc_polarity: assert property (tick && car_pos |=> !st.exc[15])
        else $error("excitation negative in the positive carrier half");

    a_update_pulse: assert property (s_cycle_end |-> s_step_seen)
        else $error("no compensator step after carrier period end");

    a_dev_capture: assert property (s_cycle_end |=> st.eps == $past(acc_sum) && st.acc == 20'sh00000)
        else $error("deviation not captured at carrier period end");

    a_angle_step: assert property (tick |=> st.ang == $past(st.ang) + $past(st.vel))
        else $error("held angle did not advance by the velocity");

    a_angle_hold: assert property (!tick |=> st.ang == $past(st.ang))
        else $error("held angle moved between sample ticks");

    a_integ_dir: assert property (cyc_end && !acc_sum[19] && acc_sum != 20'sh00000
                                  |=> st.integ > $past(st.integ))
        else $error("integrator did not rise on positive deviation");

    a_comp_quiet: assert property (!cyc_end |=> $stable(st.vel) && $stable(st.integ))
        else $error("compensator state changed outside its step");

    a_bw_manual: assert property (cyc_end && !auto_bw_en |=> st.bw == $past(st.cfg_bw))
        else $error("manual bandwidth not applied at compensator step");

    a_bw_raise: assert property (cyc_end && auto_bw_en && dev_big |=> st.bw == `RTRK_BW_MAX)
        else $error("bandwidth not raised on large deviation");

    a_bw_lower: assert property (cyc_end && auto_bw_en && dev_small && st.stable == `RTRK_STABLE_LAST
                                 && st.bw > `RTRK_BW_AUTO_MIN |=> st.bw == $past(st.bw) - 3'h1)
        else $error("bandwidth not lowered after a stable stretch");

    sequence s_smp_pulse;
        ##1 smp_tick ##1 !smp_tick;
    endsequence

    sequence s_upd_pulse;
        ##1 loop_update ##1 !loop_update;
    endsequence

    a_div_count: assert property (!tick |=> st.div == $past(st.div) + 9'h001)
        else $error("sample divider did not count up");

    a_div_wrap: assert property (tick |=> st.div == 9'h000)
        else $error("sample divider did not restart after a tick");

    a_phase_step: assert property (tick |=> st.car_ph == $past(st.car_ph) + 5'h01)
        else $error("carrier phase did not advance on a tick");

    a_phase_hold: assert property (!tick |=> $stable(st.car_ph) && $stable(st.exc))
        else $error("carrier moved between sample ticks");

    a_exc_source: assert property (tick |=> exc_ref == $past(car_sin))
        else $error("excitation not taken from the carrier table");

    // phase 16 is the zero crossing, so it is left out
    a_exc_negative: assert property (tick && !car_pos && st.car_ph != 5'h10 |=> exc_ref[15])
        else $error("excitation not negative in the negative carrier half");

    a_smp_pulse: assert property (tick |-> s_smp_pulse)
        else $error("sample tick pulse missing or too long");

    a_smp_quiet: assert property (!tick |=> !smp_tick)
        else $error("sample tick pulse without an internal tick");

    a_acc_step: assert property (tick && !cyc_end |=> st.acc == $past(acc_sum))
        else $error("detector sum not accumulated on a tick");

    a_acc_hold: assert property (!tick |=> $stable(st.acc) && $stable(st.eps))
        else $error("detector state moved between sample ticks");

    // bounded level keeps the shifted first step clear of overflow
    a_vel_first: assert property (cyc_end && st.integ == 32'sh0000_0000 && acc_sum[19] && st.bw <= 3'h3
                                  |=> speed[15])
        else $error("speed not negative after a negative deviation");

    a_upd_pulse: assert property (cyc_end |-> s_upd_pulse)
        else $error("compensator step pulse missing or too long");

    a_upd_quiet: assert property (!cyc_end |=> !loop_update)
        else $error("compensator step pulse outside carrier period end");

    a_integ_step: assert property (cyc_end |=> st.integ == $past(st.integ) + $past(i_step))
        else $error("integrator step wrong at compensator step");

    a_vel_step: assert property (cyc_end |=> st.vel == $past(integ_sum) + $past(p_term))
        else $error("velocity clamped or wrong at compensator step");

    a_bw_steady: assert property (!cyc_end |=> $stable(st.bw) && $stable(st.stable))
        else $error("bandwidth state moved outside the compensator step");

    a_cfg_load: assert property (bw_load |=> st.cfg_bw == $past(bw_sel))
        else $error("configured bandwidth not loaded");

    a_cfg_hold: assert property (!bw_load |=> $stable(st.cfg_bw))
        else $error("configured bandwidth changed without a load");

    a_manual_stable: assert property (cyc_end && !auto_bw_en |=> st.stable == 8'h00)
        else $error("stable count kept in manual bandwidth mode");

    a_stable_clear: assert property (cyc_end && auto_bw_en && !dev_small |=> st.stable == 8'h00)
        else $error("stable count kept after a non-small deviation");

    a_stable_count: assert property (cyc_end && auto_bw_en && dev_small && st.stable != `RTRK_STABLE_LAST
                                     |=> st.stable == $past(st.stable) + 8'h01)
        else $error("stable count did not advance on a small deviation");

    a_bw_no_rise: assert property (cyc_end && auto_bw_en && !dev_big |=> st.bw <= $past(st.bw))
        else $error("bandwidth raised without a large deviation");

    a_bw_floor: assert property (cyc_end && auto_bw_en && !dev_big && st.bw <= `RTRK_BW_AUTO_MIN
                                 |=> st.bw == $past(st.bw))
        else $error("bandwidth lowered below the automatic floor");

endmodule // rtrk_tracking_loop

// [design/rtrk_defs.svh]
// Purpose: constants of the resolver tracking loop
// Assumes: 100 MHz converter clock
// Notes:   gains are shift counts, bandwidth level n stands for 100 Hz << n
`ifndef RTRK_DEFS_SVH
`define RTRK_DEFS_SVH

`define RTRK_CLK_HZ         100000000
`define RTRK_EXC_HZ         10000
`define RTRK_SMP_PER_CYC    32
`define RTRK_SMP_DIV        (`RTRK_CLK_HZ / (`RTRK_EXC_HZ * `RTRK_SMP_PER_CYC))
`define RTRK_SMP_LAST       9'(`RTRK_SMP_DIV - 1)
`define RTRK_PH_LAST        5'h1F

`define RTRK_BW_BASE_HZ     100
`define RTRK_BW_DEFAULT_HZ  800
`define RTRK_BW_DEFAULT     3'h3
`define RTRK_BW_MAX         3'h7
`define RTRK_BW_AUTO_MIN    3'h1

`define RTRK_KP_SH0         5'h04
`define RTRK_KI_SH0         5'h00

`define RTRK_EPS_HI         20'h04000
`define RTRK_EPS_LO         20'h00400
`define RTRK_STABLE_LAST    8'h1F

`define RTRK_ANG_RST        32'h0000_0000
`define RTRK_VEL_RST        32'h0000_0000

`endif

// [design/rtrk_pkg.sv]
// Purpose: types of the resolver tracking loop
// Assumes: constants live in rtrk_defs.svh
// Notes:   state of the loop is one packed struct
package rtrk_pkg;

    typedef logic signed [11:0] rtrk_smp_t;
    typedef logic signed [15:0] rtrk_trig_t;
    typedef logic signed [19:0] rtrk_eps_t;
    typedef logic [2:0]         rtrk_bw_t;

    typedef struct packed {
        logic [8:0]         div;
        logic [4:0]         car_ph;
        logic signed [15:0] exc;
        logic signed [19:0] acc;
        logic signed [19:0] eps;
        logic signed [31:0] integ;
        logic signed [31:0] vel;
        logic [31:0]        ang;
        logic [2:0]         cfg_bw;
        logic [2:0]         bw;
        logic [7:0]         stable;
        logic               upd;
    } rtrk_state_s;

endpackage

// [design/rtrk_sincos.sv]
// Purpose: sine and cosine of a 16-bit angle by table and interpolation
// Assumes: full circle is 2^16, result full scale is 16'h3FFF
// Notes:   quarter-wave table of 17 points, linear interpolation between them
`timescale 1ns/10ps
module rtrk_sincos (
    input  wire logic [15:0]        ang,
    output rtrk_pkg::rtrk_trig_t    sin_v,
    output rtrk_pkg::rtrk_trig_t    cos_v
);

    function automatic logic [15:0] qtab(input logic [4:0] i);
        logic [15:0] v;
        v = 16'h3FFF;
        case (i)
            5'h00: v = 16'h0000;
            5'h01: v = 16'h0646;
            5'h02: v = 16'h0C7C;
            5'h03: v = 16'h1294;
            5'h04: v = 16'h187E;
            5'h05: v = 16'h1E2B;
            5'h06: v = 16'h238E;
            5'h07: v = 16'h289A;
            5'h08: v = 16'h2D41;
            5'h09: v = 16'h3179;
            5'h0A: v = 16'h3537;
            5'h0B: v = 16'h3871;
            5'h0C: v = 16'h3B21;
            5'h0D: v = 16'h3D3F;
            5'h0E: v = 16'h3EC5;
            5'h0F: v = 16'h3FB1;
            default: v = 16'h3FFF;
        endcase
        return v;
    endfunction

    rtrk_pkg::rtrk_trig_t res [2];

    // channel 0 is sine, channel 1 is sine advanced by a quarter turn
    for (genvar g = 0; g < 2; g++) begin : g_ch
        logic [15:0] a;
        logic [13:0] pos;
        logic [15:0] y0;
        logic [15:0] y1;
        logic [25:0] slope;
        logic [15:0] mag;
        assign a     = ang + ((g == 1) ? 16'h4000 : 16'h0000);
        // mirrored quadrants fold onto the rising quarter, one lsb of skew accepted
        assign pos   = a[14] ? ~a[13:0] : a[13:0];
        assign y0    = qtab({1'b0, pos[13:10]});
        assign y1    = qtab({1'b0, pos[13:10]} + 5'h01);
        assign slope = 26'(y1 - y0) * 26'(pos[9:0]);
        assign mag   = y0 + slope[25:10];
        assign res[g] = a[15] ? -$signed(mag) : $signed(mag);
    end

    assign sin_v = res[0];
    assign cos_v = res[1];

endmodule // rtrk_sincos

// [tb/rtrk_resolver_model.sv]
// Purpose: resolver and amplifiers, modulate the excitation by the shaft angle
// Assumes: exc_ref full scale 16'h3FFF, sample scale 2000 of 2047
// Notes:   ideal sensor; no lag, offset or mismatch, so errors come from the loop
`timescale 1ns/10ps
module rtrk_resolver_model (
    input  wire rtrk_pkg::rtrk_trig_t  exc_ref,
    input  wire logic [15:0]           theta,
    output rtrk_pkg::rtrk_smp_t        sin_out,
    output rtrk_pkg::rtrk_smp_t        cos_out
);
    real a;
    real e;
    always @* begin
        a = 6.283185307 * theta / 65536.0;
        e = 2000.0 * $itor(exc_ref) / 16383.0; // carrier taken from the converter
        sin_out = rtrk_pkg::rtrk_smp_t'($rtoi(e * $sin(a)));
        cos_out = rtrk_pkg::rtrk_smp_t'($rtoi(e * $cos(a)));
    end
endmodule // rtrk_resolver_model

// [tb/resolver_tracking_loop_tb_top.sv]
// Purpose: self-checking bench of the tracking loop against a resolver model
// Assumes: 100 MHz clk, samples held by the model between ticks
// Notes:   slow bandwidth lowering needs 32 steps, left to the design assertions
`timescale 1ns/10ps
module resolver_tracking_loop_tb_top;
    logic                  clk;
    logic                  resetn;
    rtrk_pkg::rtrk_smp_t   sin_in;
    rtrk_pkg::rtrk_smp_t   cos_in;
    rtrk_pkg::rtrk_bw_t    bw_sel;
    logic                  bw_load;
    logic                  auto_bw_en;
    rtrk_pkg::rtrk_trig_t  exc_ref;
    logic                  smp_tick;
    logic [15:0]           angle;
    logic signed [15:0]    speed;
    rtrk_pkg::rtrk_eps_t   deviation;
    rtrk_pkg::rtrk_bw_t    bw_level;
    logic                  loop_update;
    logic [15:0]           theta;
    int                    miscompares;
    int                    check_count;
    int                    seed;
    int                    cyc;
    int                    tk;
    int                    pos;
    int                    neg;
    int                    e0;
    bit                    seen;

    rtrk_tracking_loop rtrk_tracking_loop_i (.clk(clk), .resetn(resetn), .sin_in(sin_in), .cos_in(cos_in),
        .bw_sel(bw_sel), .bw_load(bw_load), .auto_bw_en(auto_bw_en), .exc_ref(exc_ref), .smp_tick(smp_tick),
        .angle(angle), .speed(speed), .deviation(deviation), .bw_level(bw_level), .loop_update(loop_update));
    rtrk_resolver_model rtrk_resolver_model_i (.exc_ref(exc_ref), .theta(theta), .sin_out(sin_in),
        .cos_out(cos_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%0h expected=%0h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d miscompares=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // bounded wait for n compensator steps
    task automatic wait_upd(input int n);
        int k;
        for (int i = 0; i < n; i++) begin
            for (k = 0; k < 12000; k++) begin
                @(posedge clk);
                #1;
                if (loop_update === 1'b1) break;
            end
            if (k == 12000) begin
                miscompares++;
                results();
            end
        end
    endtask

    // angle within lim of theta, measured the short way round
    function automatic bit near(input logic [15:0] a, input logic [15:0] t, input int lim);
        logic signed [15:0] d;
        d = $signed(t - a);
        return (d < 0 ? -int'(d) : int'(d)) < lim;
    endfunction

    always @(posedge clk) begin
        #1;
        if (resetn !== 1'b1) begin
            cyc = 0;
            tk = 0;
            pos = 0;
            neg = 0;
            seen = 0;
        end else begin
            cyc++;
            if (smp_tick === 1'b1) begin
                if (seen) check(cyc, 312);
                seen = 1;
                cyc = 0;
                tk++;
                if ($signed(exc_ref) > 0) pos++;
                if ($signed(exc_ref) < 0) neg++;
            end
            if (loop_update === 1'b1) begin
                check(tk, 32);
                check({pos[7:0], neg[7:0]}, 16'h0F0F);
                tk = 0;
                pos = 0;
                neg = 0;
            end
        end
    end

    initial begin
        seed = 32'hC694;
        miscompares = 0;
        check_count = 0;
        resetn = 1'b0;
        bw_sel = 3'h0;
        bw_load = 1'b0;
        auto_bw_en = 1'b0;
        theta = 16'h0000;
        repeat (20) @(posedge clk);
        #1;
        check({exc_ref, angle}, 32'h0);
        check({speed, bw_level, smp_tick, loop_update}, {16'h0000, 3'h3, 2'h0});
        check(deviation, 32'h0);
        // negative input angle: the held angle must wrap below zero
        e0 = 32'h400 + ({$random(seed)} % 32'h800);
        theta = 16'h0000 - 16'(e0);
        resetn = 1'b1;
        wait_upd(1);
        check(deviation[19], 1'b1);
        check(speed[15], 1'b1);
        wait_upd(3);
        check(angle[15], 1'b1);
        check(near(angle, theta, e0 / 2), 1'b1);
        // step of a quarter turn with automatic bandwidth on
        auto_bw_en = 1'b1;
        theta = theta + 16'h4000;
        wait_upd(2);
        check(bw_level, 3'h7);
        // configured level comes back once automatic mode is off
        auto_bw_en = 1'b0;
        for (int i = 0; i < 2; i++) begin
            bw_sel = (i == 0) ? rtrk_pkg::rtrk_bw_t'($random(seed)) : 3'h0;
            bw_load = 1'b1;
            @(posedge clk);
            #1;
            bw_load = 1'b0;
            wait_upd(1);
            check(bw_level, bw_sel);
        end
        results();
    end
endmodule // resolver_tracking_loop_tb_top
